// ==== hw/quadrature_decoder_pkg.sv ====
/*
 * Constants, register map and carrier types of the quadrature decoder
 * task, event and shortcut control.
 * Assumes a 10 MHz system clock and a 12-bit register byte address.
 */
package quadrature_decoder_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_START_TRIGGER         = 12'h000;
   localparam logic [11:0] OFS_STOP_TRIGGER          = 12'h004;
   localparam logic [11:0] OFS_CLEAR_BOTH_TRIGGER    = 12'h008;
   localparam logic [11:0] OFS_CLEAR_MOTION_TRIGGER  = 12'h00C;
   localparam logic [11:0] OFS_CLEAR_DOUBLE_TRIGGER  = 12'h010;
   localparam logic [11:0] OFS_NEW_SAMPLE_FLAG       = 12'h100;
   localparam logic [11:0] OFS_MOVEMENT_REPORT_FLAG  = 12'h104;
   localparam logic [11:0] OFS_OVERFLOW_FLAG         = 12'h108;
   localparam logic [11:0] OFS_DOUBLE_REPORT_FLAG    = 12'h10C;
   localparam logic [11:0] OFS_HALTED_FLAG           = 12'h110;
   localparam logic [11:0] OFS_EVENT_TASK_LINKS      = 12'h200;
   localparam logic [11:0] OFS_IRQ_ENABLE_SET        = 12'h304;
   localparam logic [11:0] OFS_IRQ_ENABLE_CLEAR      = 12'h308;
   localparam logic [11:0] OFS_DECODER_ENABLE        = 12'h500;
   localparam logic [11:0] OFS_SAMPLE_INTERVAL       = 12'h508;
   localparam logic [11:0] OFS_MOTION_SAMPLE         = 12'h50C;
   localparam logic [11:0] OFS_REPORT_INTERVAL       = 12'h510;
   localparam logic [11:0] OFS_MOTION_ACCUMULATOR    = 12'h514;
   localparam logic [11:0] OFS_MOTION_SNAPSHOT       = 12'h518;
   localparam logic [11:0] OFS_DOUBLE_COUNTER        = 12'h544;
   localparam logic [11:0] OFS_DOUBLE_SNAPSHOT       = 12'h548;

   // ---------------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------------
   localparam int          NUM_EVENTS        = 5;
   localparam int          NUM_LINKS         = 7;
   localparam logic [6:0]  LINKS_RESET       = 7'h00;
   localparam logic [4:0]  IRQ_ENABLE_RESET  = 5'h00;
   localparam logic [3:0]  SAMPLE_INT_RESET  = 4'h0;
   localparam logic [3:0]  SAMPLE_INT_MAX    = 4'hA;
   localparam logic [3:0]  REPORT_INT_RESET  = 4'h0;
   // Link bit positions
   localparam int LNK_REPORT_CLEAR_BOTH   = 0;
   localparam int LNK_SAMPLE_STOP         = 1;
   localparam int LNK_REPORT_CLEAR_MOTION = 2;
   localparam int LNK_REPORT_STOP         = 3;
   localparam int LNK_DOUBLE_CLEAR_DOUBLE = 4;
   localparam int LNK_DOUBLE_STOP         = 5;
   localparam int LNK_SAMPLE_CLEAR_BOTH   = 6;

   // ---------------------------------------------------------------
   // Accumulator ranges
   // ---------------------------------------------------------------
   localparam logic signed [10:0] MOTION_MAX = 11'sh3FF;
   localparam logic signed [10:0] MOTION_MIN = -11'sh400;
   localparam logic [3:0]         DOUBLE_MAX = 4'hF;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_FREQ_MHZ       = 10;
   localparam int SAMPLE_BASE_US     = 128;
   localparam int SAMPLE_BASE_CYCLES = SAMPLE_BASE_US * CLK_FREQ_MHZ;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic halted;
      logic double_report;
      logic overflow;
      logic movement_report;
      logic new_sample;
   } event_set_t;

   typedef struct packed {
      logic clear_double;
      logic clear_motion;
      logic clear_both;
      logic stop;
      logic start;
   } task_set_t;

   // Samples per report for each interval code
   function automatic logic [8:0] report_samples(input logic [3:0] code);
      case (code)
         4'h0:    report_samples = 9'h00A;
         4'h1:    report_samples = 9'h028;
         4'h2:    report_samples = 9'h050;
         4'h3:    report_samples = 9'h078;
         4'h4:    report_samples = 9'h0A0;
         4'h5:    report_samples = 9'h0C8;
         4'h6:    report_samples = 9'h0F0;
         4'h7:    report_samples = 9'h118;
         4'h8:    report_samples = 9'h001;
         default: report_samples = 9'h00A;
      endcase
   endfunction : report_samples

endpackage : quadrature_decoder_pkg

// ==== hw/quadrature_decoder_task_event_ctrl.sv ====
/*
 * Task, event, shortcut and interrupt-enable control of a quadrature
 * decoder, with sample timer, motion accumulator and double-transition
 * counter.
 * Assumes phase inputs already synchronous to clk_sys and a register
 * master that never issues read and write strobes together.
 */
// Notes on behaviour
// - Start task runs periodic sampling
// - Stop task halts sampling
// - Clear-both snapshots and zeroes both atomically
// - Clear-motion snapshots and zeroes motion only
// - Clear-double snapshots and zeroes double only
// - Every new sample sets new-sample flag
// - Report period end, motion nonzero: report
// - Accumulator overflow sets overflow flag
// - Report period end, doubles nonzero: report
// - Stop sets halted flag
// - Movement report links to three tasks
// - New sample links to stop, clear-both
// - Double report links to clear-double, stop
// - Event flags readable and writable bits
// - Enable-set writes of one enable
// - Enable-set reads current enables
// - Enable-clear writes of one disable
// - Only plus or minus one accumulates
// - Overflowing sample dropped, others kept
// - Double counter counts double transitions
module quadrature_decoder_task_event_ctrl #(
   parameter logic [23:0] SAMPLE_BASE =
      24'(quadrature_decoder_pkg::SAMPLE_BASE_CYCLES)
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // Register port
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [31:0] rdata,
   // Encoder phases
   input  wire logic        phase_a,
   input  wire logic        phase_b,
   // Status
   output logic             irq,
   output logic             running
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   quadrature_decoder_pkg::event_set_t event_flags;
   quadrature_decoder_pkg::task_set_t  linked_tasks;
   logic        [4:0]  irq_enable;
   logic        [6:0]  event_task_links;
   logic               decoder_enable;
   logic        [3:0]  sample_interval_setting;
   logic        [3:0]  report_interval_setting;
   logic signed [2:0]  motion_sample;
   logic signed [10:0] motion_accumulator;
   logic signed [10:0] motion_snapshot;
   logic        [3:0]  double_transition_counter;
   logic        [3:0]  double_transition_snapshot;
   logic        [23:0] tick_count;
   logic        [8:0]  report_count;
   logic        [1:0]  prev_phase;

   // ---------------------------------------------------------------
   // Register write decode
   // ---------------------------------------------------------------
   wire logic wr_one = wr_en & wdata[0];
   quadrature_decoder_pkg::task_set_t sw_tasks;
   assign sw_tasks.start        = wr_one &
      (addr == quadrature_decoder_pkg::OFS_START_TRIGGER);
   assign sw_tasks.stop         = wr_one &
      (addr == quadrature_decoder_pkg::OFS_STOP_TRIGGER);
   assign sw_tasks.clear_both   = wr_one &
      (addr == quadrature_decoder_pkg::OFS_CLEAR_BOTH_TRIGGER);
   assign sw_tasks.clear_motion = wr_one &
      (addr == quadrature_decoder_pkg::OFS_CLEAR_MOTION_TRIGGER);
   assign sw_tasks.clear_double = wr_one &
      (addr == quadrature_decoder_pkg::OFS_CLEAR_DOUBLE_TRIGGER);

   wire logic wr_links  = wr_en &
      (addr == quadrature_decoder_pkg::OFS_EVENT_TASK_LINKS);
   wire logic wr_ie_set = wr_en &
      (addr == quadrature_decoder_pkg::OFS_IRQ_ENABLE_SET);
   wire logic wr_ie_clr = wr_en &
      (addr == quadrature_decoder_pkg::OFS_IRQ_ENABLE_CLEAR);
   wire logic wr_enable = wr_en &
      (addr == quadrature_decoder_pkg::OFS_DECODER_ENABLE);
   wire logic wr_s_int  = wr_en &
      (addr == quadrature_decoder_pkg::OFS_SAMPLE_INTERVAL);
   wire logic wr_r_int  = wr_en &
      (addr == quadrature_decoder_pkg::OFS_REPORT_INTERVAL);

   // Software and linked triggers act alike
   quadrature_decoder_pkg::task_set_t tasks;
   assign tasks = sw_tasks | linked_tasks;

   wire logic do_stop  = tasks.stop;
   wire logic do_start = tasks.start & ~tasks.stop;
   wire logic clear_motion = tasks.clear_both |
                             tasks.clear_motion;
   wire logic clear_double = tasks.clear_both |
                             tasks.clear_double;

   // ---------------------------------------------------------------
   // Sample timer
   // ---------------------------------------------------------------
   wire logic [3:0] interval_code =
      (sample_interval_setting > quadrature_decoder_pkg::SAMPLE_INT_MAX) ?
      quadrature_decoder_pkg::SAMPLE_INT_MAX : sample_interval_setting;
   wire logic [23:0] sample_period = SAMPLE_BASE << interval_code;
   wire logic sampling = running & decoder_enable;
   wire logic tick = sampling &
      (tick_count == sample_period - 24'h000001);
   wire logic [23:0] next_tick_count =
      (!sampling || tick || do_start) ? 24'h000000 :
      tick_count + 24'h000001;

   // ---------------------------------------------------------------
   // Transition decode
   // ---------------------------------------------------------------
   wire logic [1:0] cur_phase = {phase_a, phase_b};
   wire logic [1:0] phase_diff = cur_phase ^ prev_phase;
   wire logic is_double = tick & (phase_diff == 2'b11);
   wire logic is_step   = tick & (phase_diff == 2'b01 ||
                                  phase_diff == 2'b10);
   wire logic step_up   = prev_phase[1] ^ cur_phase[0];
   wire logic signed [2:0] next_motion_sample =
      is_double ? 3'sh2 :
      is_step   ? (step_up ? 3'sh1 : -3'sh1) :
      3'sh0;

   // ---------------------------------------------------------------
   // Accumulators
   // ---------------------------------------------------------------
   wire logic motion_over = is_step & (step_up ?
      (motion_accumulator == quadrature_decoder_pkg::MOTION_MAX) :
      (motion_accumulator == quadrature_decoder_pkg::MOTION_MIN));
   wire logic motion_add = is_step & ~motion_over;
   wire logic signed [10:0] motion_sum = !motion_add ?
      motion_accumulator :
      (step_up ? motion_accumulator + 11'sh001 :
                 motion_accumulator - 11'sh001);
   wire logic double_over = is_double &
      (double_transition_counter == quadrature_decoder_pkg::DOUBLE_MAX);
   wire logic [3:0] double_sum = (is_double & ~double_over) ?
      double_transition_counter + 4'h1 :
      double_transition_counter;

   // Current sample is folded into the snapshot so none is lost
   wire logic signed [10:0] next_motion_accumulator =
      clear_motion ? 11'sh000 : motion_sum;
   wire logic [3:0] next_double_counter =
      clear_double ? 4'h0 : double_sum;

   // ---------------------------------------------------------------
   // Report period
   // ---------------------------------------------------------------
   wire logic [8:0] report_target =
      quadrature_decoder_pkg::report_samples(report_interval_setting);
   wire logic report_due = tick &
      (report_count + 9'h001 >= report_target);
   wire logic [8:0] next_report_count =
      (do_start || report_due) ? 9'h000 :
      tick ? report_count + 9'h001 : report_count;

   // ---------------------------------------------------------------
   // Events
   // ---------------------------------------------------------------
   quadrature_decoder_pkg::event_set_t events;
   assign events.new_sample      = tick;
   assign events.movement_report = report_due &
                                   (motion_sum != 11'sh000);
   assign events.overflow        = motion_over | double_over;
   assign events.double_report   = report_due &
                                   (double_sum != 4'h0);
   assign events.halted          = do_stop;

   // ---------------------------------------------------------------
   // Event to task links
   // ---------------------------------------------------------------
   quadrature_decoder_pkg::task_set_t next_linked_tasks;
   assign next_linked_tasks.start        = 1'b0;
   assign next_linked_tasks.stop         =
      (events.new_sample &
       event_task_links[quadrature_decoder_pkg::LNK_SAMPLE_STOP]) |
      (events.movement_report &
       event_task_links[quadrature_decoder_pkg::LNK_REPORT_STOP]) |
      (events.double_report &
       event_task_links[quadrature_decoder_pkg::LNK_DOUBLE_STOP]);
   assign next_linked_tasks.clear_both   =
      (events.movement_report &
       event_task_links[quadrature_decoder_pkg::LNK_REPORT_CLEAR_BOTH]) |
      (events.new_sample &
       event_task_links[quadrature_decoder_pkg::LNK_SAMPLE_CLEAR_BOTH]);
   assign next_linked_tasks.clear_motion = events.movement_report &
      event_task_links[quadrature_decoder_pkg::LNK_REPORT_CLEAR_MOTION];
   assign next_linked_tasks.clear_double = events.double_report &
      event_task_links[quadrature_decoder_pkg::LNK_DOUBLE_CLEAR_DOUBLE];

   // ---------------------------------------------------------------
   // Event flags
   // ---------------------------------------------------------------
   localparam logic [11:0] EVENT_OFS [quadrature_decoder_pkg::NUM_EVENTS] =
      '{quadrature_decoder_pkg::OFS_NEW_SAMPLE_FLAG,
        quadrature_decoder_pkg::OFS_MOVEMENT_REPORT_FLAG,
        quadrature_decoder_pkg::OFS_OVERFLOW_FLAG,
        quadrature_decoder_pkg::OFS_DOUBLE_REPORT_FLAG,
        quadrature_decoder_pkg::OFS_HALTED_FLAG};

   logic [4:0] next_flags;
   logic [4:0] flag_hit;
   genvar gi;
   generate
      for (gi = 0; gi < quadrature_decoder_pkg::NUM_EVENTS; gi++) begin : g_flag
         assign flag_hit[gi]   = (addr == EVENT_OFS[gi]);
         // Hardware set wins over a software write
         assign next_flags[gi] = events[gi] ? 1'b1 :
            (wr_en & flag_hit[gi]) ? wdata[0] :
            event_flags[gi];
      end
   endgenerate

   wire logic [4:0] next_irq_enable = wr_ie_set ?
      (irq_enable | wdata[4:0]) :
      wr_ie_clr ? (irq_enable & ~wdata[4:0]) :
      irq_enable;

   wire logic next_running = do_stop ? 1'b0 :
                             do_start ? 1'b1 : running;

   // ---------------------------------------------------------------
   // Read selection
   // ---------------------------------------------------------------
   wire logic [31:0] read_value =
      (|flag_hit) ? {31'h00000000, |(flag_hit & event_flags)} :
      (addr == quadrature_decoder_pkg::OFS_EVENT_TASK_LINKS) ?
         {25'h0000000, event_task_links} :
      (addr == quadrature_decoder_pkg::OFS_IRQ_ENABLE_SET ||
       addr == quadrature_decoder_pkg::OFS_IRQ_ENABLE_CLEAR) ?
         {27'h0000000, irq_enable} :
      (addr == quadrature_decoder_pkg::OFS_DECODER_ENABLE) ?
         {31'h00000000, decoder_enable} :
      (addr == quadrature_decoder_pkg::OFS_SAMPLE_INTERVAL) ?
         {28'h0000000, sample_interval_setting} :
      (addr == quadrature_decoder_pkg::OFS_MOTION_SAMPLE) ?
         32'(motion_sample) :
      (addr == quadrature_decoder_pkg::OFS_REPORT_INTERVAL) ?
         {28'h0000000, report_interval_setting} :
      (addr == quadrature_decoder_pkg::OFS_MOTION_ACCUMULATOR) ?
         32'(motion_accumulator) :
      (addr == quadrature_decoder_pkg::OFS_MOTION_SNAPSHOT) ?
         32'(motion_snapshot) :
      (addr == quadrature_decoder_pkg::OFS_DOUBLE_COUNTER) ?
         {28'h0000000, double_transition_counter} :
      (addr == quadrature_decoder_pkg::OFS_DOUBLE_SNAPSHOT) ?
         {28'h0000000, double_transition_snapshot} :
      32'h00000000;

   // ---------------------------------------------------------------
   // Registers: control and configuration
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         event_task_links        <= quadrature_decoder_pkg::LINKS_RESET;
         irq_enable              <= quadrature_decoder_pkg::IRQ_ENABLE_RESET;
         decoder_enable          <= 1'b0;
         sample_interval_setting <= quadrature_decoder_pkg::SAMPLE_INT_RESET;
         report_interval_setting <= quadrature_decoder_pkg::REPORT_INT_RESET;
      end else begin
         if (wr_links) begin
            event_task_links <= wdata[6:0];
         end
         irq_enable <= next_irq_enable;
         if (wr_enable) begin
            decoder_enable <= wdata[0];
         end
         if (wr_s_int) begin
            sample_interval_setting <= wdata[3:0];
         end
         if (wr_r_int) begin
            report_interval_setting <= wdata[3:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers: decoder state and events
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         running      <= 1'b0;
         event_flags  <= '0;
         linked_tasks <= '0;
         tick_count   <= 24'h000000;
         report_count <= 9'h000;
         prev_phase   <= 2'b00;
         irq          <= 1'b0;
         rdata        <= 32'h00000000;
      end else begin
         running      <= next_running;
         event_flags  <= next_flags;
         linked_tasks <= next_linked_tasks;
         tick_count   <= next_tick_count;
         report_count <= next_report_count;
         if (do_start || tick) begin
            prev_phase <= cur_phase;
         end
         irq   <= |(event_flags & irq_enable);
         rdata <= rd_en ? read_value : 32'h00000000;
      end
   end

   // ---------------------------------------------------------------
   // Registers: sample and accumulators
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         motion_sample              <= 3'sh0;
         motion_accumulator         <= 11'sh000;
         motion_snapshot            <= 11'sh000;
         double_transition_counter  <= 4'h0;
         double_transition_snapshot <= 4'h0;
      end else begin
         if (tick) begin
            motion_sample <= next_motion_sample;
         end
         motion_accumulator        <= next_motion_accumulator;
         double_transition_counter <= next_double_counter;
         if (clear_motion) begin
            motion_snapshot <= motion_sum;
         end
         if (clear_double) begin
            double_transition_snapshot <= double_sum;
         end
      end
   end

endmodule : quadrature_decoder_task_event_ctrl

// ==== testbench/encoder_model.sv ====
/* Behavioural quadrature encoder.
   Assumes its step period equals the decoder sample tick. */
module encoder_model #(
   parameter int PERIOD = 4
) (
   // Clock, reset and motion command
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic [1:0] mode,
   // Phases
   output logic            phase_a,
   output logic            phase_b
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] pos;
   int         div;
   // --------------------
   // Gray-coded position, one step per period in modes 1 and 2, two steps in mode 3, none in mode 0
   // --------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pos <= 2'h0;
         div <= 0;
      end else begin
         div <= (div == PERIOD - 1) ? 0 : div + 1;
         if (div == 0)
            pos <= pos + ((mode == 2'h2) ? 2'h3 : (mode == 2'h3) ? 2'h2 : mode);
      end
   end
   assign phase_a = pos[1];
   assign phase_b = pos[1] ^ pos[0];
endmodule : encoder_model

// ==== testbench/quadrature_decoder_task_event_ctrl_chk.sv ====
/* Port checker for the quadrature decoder control block.
   Assumes one-cycle strobes and registered read data on clk_sys. */
module quadrature_decoder_task_event_ctrl_chk (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        nrst,
   // Register port
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [31:0] rdata,
   // Status
   input wire logic        irq,
   input wire logic        running
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // --------------------
   // Task strobes
   // --------------------
   sequence start_wr;
      wr_en && addr == 12'h000 && wdata[0];
   endsequence
   sequence stop_wr;
      wr_en && addr == 12'h004 && wdata[0];
   endsequence
   // --------------------
   // Port relations
   // --------------------
   rdata_idle_a: assert property (!rd_en |=> rdata == 32'h0)
      else $error("read data not zero outside a read");
   start_run_a: assert property (start_wr and !running |=> running)
      else $error("start task did not set running");
   stop_halt_a: assert property (stop_wr |=> !running)
      else $error("stop task left decoder running");
   stop_flag_a: assert property (stop_wr ##1 !wr_en
      ##1 (rd_en && addr == 12'h110) |=> rdata[0])
      else $error("halted flag not set after stop");
   links_read_a: assert property (rd_en && addr == 12'h200
      |=> rdata[31:7] == 25'h0)
      else $error("link register upper bits not zero");
   ien_read_a: assert property (rd_en && addr[11:4] == 8'h30
      |=> rdata[31:5] == 27'h0)
      else $error("enable register upper bits not zero");
   flag_read_a: assert property (rd_en && addr[11:8] == 4'h1
      |=> rdata[31:1] == 31'h0)
      else $error("flag read upper bits not zero");
   unmapped_a: assert property (rd_en && addr == 12'hE00 |=> rdata == 0)
      else $error("unmapped read not zero");
   irq_off_a: assert property (wr_en && addr == 12'h308
      && wdata[4:0] == 5'h1F ##1 !(wr_en && addr == 12'h304) |=> !irq)
      else $error("interrupt stayed high with all enables off");
endmodule : quadrature_decoder_task_event_ctrl_chk

bind quadrature_decoder_task_event_ctrl quadrature_decoder_task_event_ctrl_chk
   u_chk (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
   .running(running));

// ==== testbench/quadrature_decoder_task_event_ctrl_tb.sv ====
/* Self-checking bench for the quadrature decoder control block.
   Assumes a sample tick of 4 cycles and a matching encoder model. */
module quadrature_decoder_task_event_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 1'b0;
   logic        nrst    = 1'b0;
   logic [11:0] addr    = 12'h000;
   logic [31:0] wdata   = 32'h0;
   logic        wr_en   = 1'b0;
   logic        rd_en   = 1'b0;
   logic [1:0]  mode    = 2'h0;
   logic [31:0] rdata;
   logic        phase_a, phase_b, irq, running;
   int          n_mismatch = 0;
   int          checks = 0;
   int          cyc = 0;
   logic [31:0] lk [4] = '{32'h0C, 32'h09, 32'h42, 32'h30};
   logic [1:0]  md [4] = '{2'h1, 2'h1, 2'h1, 2'h3};
   logic [11:0] sn [4] = '{12'h518, 12'h518, 12'h518, 12'h548};

   quadrature_decoder_task_event_ctrl #(.SAMPLE_BASE(24'h000004))
      u_quadrature_decoder_task_event_ctrl (.clk_sys(clk_sys), .nrst(nrst),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .phase_a(phase_a), .phase_b(phase_b), .irq(irq),
      .running(running));
   encoder_model #(.PERIOD(4)) u_encoder_model (.clk_sys(clk_sys),
      .nrst(nrst), .mode(mode), .phase_a(phase_a), .phase_b(phase_b));

   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // --------------------
   // Bus and compare tasks
   // --------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      @(negedge clk_sys);
      v = rdata;
   endtask : rd
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(v, e);
   endtask : rchk
   task automatic run(input logic [1:0] m, input int n);
      @(posedge clk_sys);
      mode <= m;
      wr(12'h000, 32'h1);
      @(negedge clk_sys);
      chk({31'h0, running}, 32'h1);
      repeat (n) @(negedge clk_sys);
   endtask : run
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   // --------------------
   // Test sequence
   // --------------------
   initial begin
      logic [31:0] acc;
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      rchk(12'h200, 32'h0);
      rchk(12'h304, 32'h0);
      rchk(12'h110, 32'h0);
      rchk(12'hE00, 32'h0);
      wr(12'h200, 32'hFFFFFFFF);
      rchk(12'h200, 32'h7F);
      wr(12'h200, 32'h0);
      $display("test registers done");
      wr(12'h304, 32'h1F);
      wr(12'h304, 32'h0);
      rchk(12'h304, 32'h1F);
      wr(12'h308, 32'h0F);
      rchk(12'h308, 32'h10);
      chk({31'h0, irq}, 32'h0);
      wr(12'h004, 32'h1);
      rchk(12'h110, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(12'h110, 32'h0);
      rchk(12'h110, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("test interrupt done");
      wr(12'h500, 32'h1);
      wr(12'h510, 32'h8);
      run(2'h1, 40);
      wr(12'h004, 32'h1);
      rd(12'h514, acc);
      chk({31'h0, running}, 32'h0);
      chk({31'h0, acc[31] | (acc == 32'h0)}, 32'h0);
      rchk(12'h100, 32'h1);
      rchk(12'h50C, 32'h1);
      rchk(12'h104, 32'h1);
      wr(12'h008, 32'h1);
      rchk(12'h518, acc);
      rchk(12'h514, 32'h0);
      $display("test forward done");
      run(2'h3, 100);
      wr(12'h004, 32'h1);
      rchk(12'h544, 32'hF);
      rchk(12'h108, 32'h1);
      rchk(12'h10C, 32'h1);
      rchk(12'h50C, 32'h2);
      rchk(12'h514, 32'h0);
      $display("test double done");
      foreach (lk[i]) begin
         wr(12'h200, lk[i]);
         run(md[i], 20);
         chk({31'h0, running}, 32'h0);
         rchk(sn[i], 32'h1);
         rchk(sn[i] - 12'h004, 32'h0);
         if (i == 0) begin
            rchk(12'h544, 32'hF);
            wr(12'h010, 32'h1);
            rchk(12'h548, 32'hF);
            rchk(12'h544, 32'h0);
         end
      end
      wr(12'h308, 32'h1F);
      rchk(12'h304, 32'h0);
      $display("test links done");
      tally_and_finish();
   end
endmodule : quadrature_decoder_task_event_ctrl_tb
